/* verilog/sef_front_end.sv */
// serial eeprom bus front end with apb register access
//
// Summary of operation
// - serial out changes on falling clock
// - serial in captured on rising clock
// - deselected: output released to high impedance
// - first select needs a falling select edge
// - all bytes move most significant first
// - first bit on first rise after select
// - read bytes msb first, from next fall
// - pause starts while selected and clock low
// - pause ends when released with clock low
// - paused: output released, clock and data ignored
// - pause keeps bit and byte position
// - deselect while paused resets interface; a complete command still executes
// - complete write command starts cycle on deselect
// - nothing accepted before power-on reset releases
// - reset: deselected, latch and busy cleared
// - standby only when no write cycle runs
// - protect input freezes guarded area size
// - select must rise right after last bit
// - unknown code: ignore until select rises
// - busy flag reads one during write cycles
`timescale 1ns/1ps
module sef_front_end
#(
  parameter int WR_CYCLES = sef_pkg::WR_CYCLES_DEF
)
(
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial pins
  input  wire logic        serial_clock_in,
  input  wire logic        serial_in,
  input  wire logic        select_n,
  input  wire logic        pause_n,
  input  wire logic        protect_n,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  // device state
  output logic             standby
);

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] pin_raw;
  logic [4:0] sync1;
  logic [4:0] sync2;
  assign pin_raw = {protect_n, pause_n, select_n, serial_in,
                    serial_clock_in};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_sync
      // two flops per pin
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
        end
        else
        begin
          sync1[gi] <= pin_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  logic sck;
  logic sdi;
  logic csn;
  logic hold_n;
  logic wp_n;
  assign sck    = sync2[0];
  assign sdi    = sync2[1];
  assign csn    = sync2[2];
  assign hold_n = sync2[3];
  assign wp_n   = sync2[4];

  //////////////////////////////////////////////////////////////////////
  // state
  logic          sck_q;
  logic          csn_q;
  logic          armed;
  logic [1:0]    warm;
  logic          selected;
  logic          paused;
  logic          discard;
  logic [2:0]    bit_cnt;
  logic [2:0]    byte_cnt;
  logic [6:0]    shreg;
  logic [7:0]    opcode;
  logic [15:0]   addr;
  logic [7:0]    wdata;
  logic          rd_mode;
  logic          driving;
  logic [2:0]    tx_cnt;
  logic [7:0]    tx_sh;
  logic          write_enable_latch;
  logic          busy;
  sef_pkg::sef_wr_t wr_kind;
  logic [31:0]   wr_cnt;
  logic [7:0]    nvbits;
  logic [7:0]    nv_pend;
  logic [7:0]    rd_data;
  logic [9:0]    wi_addr;
  logic [7:0]    wi_data;

  //////////////////////////////////////////////////////////////////////
  // edge and byte decode
  logic       sel_fall;
  logic       desel;
  logic       active;
  logic       rise;
  logic       fall;
  logic       byte_done;
  logic [7:0] byte_in;
  logic       op_valid;
  logic       hw_locked;
  logic       guarded;
  logic       exact;
  logic       do_wren;
  logic       do_wrdi;
  logic       do_wrsr;
  logic       do_write;
  logic [7:0] status_byte;
  logic [7:0] tx_byte;

  // select only after a seen-high then falling select line
  assign sel_fall = armed & csn_q & ~csn;
  assign desel    = selected & csn;
  // edges ignored while paused or after an unknown code
  assign active   = selected & ~csn & ~paused & ~discard;
  assign rise     = active & sck & ~sck_q;
  assign fall     = active & ~sck & sck_q;
  assign byte_done = rise & (bit_cnt == 3'h7);
  assign byte_in  = {shreg, sdi};

  assign op_valid = (byte_in == sef_pkg::OP_WREN)
                  | (byte_in == sef_pkg::OP_WRDI)
                  | (byte_in == sef_pkg::OP_RDSR)
                  | (byte_in == sef_pkg::OP_WRSR)
                  | (byte_in == sef_pkg::OP_READ)
                  | (byte_in == sef_pkg::OP_WRITE);

  // protect input freezes the guard bits
  assign hw_locked = nvbits[sef_pkg::NV_LOCK] & ~wp_n;

  // address inside the guarded area
  function automatic logic in_guard(input logic [1:0] g,
                                    input logic [9:0] a);
    case (g)
      2'b01:   in_guard = a >= sef_pkg::GUARD_QUARTER;
      2'b10:   in_guard = a >= sef_pkg::GUARD_HALF;
      2'b11:   in_guard = 1'b1;
      default: in_guard = 1'b0;
    endcase
  endfunction
  assign guarded = in_guard(
    nvbits[sef_pkg::NV_GUARD_HI:sef_pkg::NV_GUARD_LO], addr[9:0]);

  // select rose on a byte boundary, no extra bit
  assign exact    = desel & ~discard & (bit_cnt == 3'h0);
  assign do_wren  = exact & (opcode == sef_pkg::OP_WREN)
                  & (byte_cnt == sef_pkg::BYTE_A1);
  assign do_wrdi  = exact & (opcode == sef_pkg::OP_WRDI)
                  & (byte_cnt == sef_pkg::BYTE_A1);
  assign do_wrsr  = exact & (opcode == sef_pkg::OP_WRSR)
                  & (byte_cnt == sef_pkg::BYTE_A2)
                  & write_enable_latch & ~busy & ~hw_locked;
  // full write with whole data bytes starts the cycle
  assign do_write = exact & (opcode == sef_pkg::OP_WRITE)
                  & (byte_cnt == sef_pkg::BYTE_SAT)
                  & write_enable_latch & ~busy & ~guarded;

  assign status_byte = {nvbits[sef_pkg::NV_LOCK], 3'h0,
    nvbits[sef_pkg::NV_GUARD_HI:sef_pkg::NV_GUARD_LO], write_enable_latch, busy};
  assign tx_byte = (opcode == sef_pkg::OP_RDSR) ? status_byte : rd_data;

  //////////////////////////////////////////////////////////////////////
  // select, pause and shift state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sck_q    <= 1'b0;
      csn_q    <= 1'b1;
      armed    <= 1'b0;
      warm     <= 2'b00;
      selected <= 1'b0;
      paused   <= 1'b0;
      discard  <= 1'b0;
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
      shreg    <= 7'h00;
      opcode   <= 8'h00;
      addr     <= 16'h0000;
      wdata    <= 8'h00;
      rd_mode  <= 1'b0;
    end
    else
    begin
      sck_q <= sck;
      csn_q <= csn;
      // synchroniser holds a real pin sample only after two edges
      warm <= {warm[0], 1'b1};
      if (csn && warm[1])
        armed <= 1'b1;
      // deselect or new select resets the interface
      if (csn || sel_fall)
      begin
        selected <= sel_fall;
        paused   <= 1'b0;
        discard  <= 1'b0;
        bit_cnt  <= 3'h0;
        byte_cnt <= 3'h0;
        rd_mode  <= 1'b0;
      end
      else
      begin
        // pause follows pin only while clock low
        if (selected && !sck)
          paused <= ~hold_n;
        if (rise)
        begin
          shreg   <= byte_in[6:0];
          bit_cnt <= bit_cnt + 3'h1;
        end
        if (byte_done)
        begin
          if (byte_cnt != sef_pkg::BYTE_SAT)
            byte_cnt <= byte_cnt + 3'h1;
          case (byte_cnt)
            sef_pkg::BYTE_OP:
            begin
              opcode  <= byte_in;
              discard <= ~op_valid;
              rd_mode <= byte_in == sef_pkg::OP_RDSR;
            end
            sef_pkg::BYTE_A1:
            begin
              addr[15:8] <= byte_in;
              wdata      <= byte_in;
            end
            sef_pkg::BYTE_A2:
            begin
              addr[7:0] <= byte_in;
              rd_mode   <= opcode == sef_pkg::OP_READ;
            end
            default:
              wdata <= byte_in;
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output shifter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      driving    <= 1'b0;
      tx_cnt     <= 3'h0;
      tx_sh      <= 8'h00;
      serial_out <= 1'b0;
    end
    else if (csn || sel_fall)
    begin
      driving <= 1'b0;
      tx_cnt  <= 3'h0;
    end
    // first fall in read mode (after the status instruction, or after the read address) loads a byte
    else if (fall && rd_mode)
    begin
      driving <= 1'b1;
      if (tx_cnt == 3'h0)
      begin
        serial_out <= tx_byte[7];
        tx_sh      <= {tx_byte[6:0], 1'b0};
        tx_cnt     <= 3'h7;
      end
      else
      begin
        serial_out <= tx_sh[7];
        tx_sh      <= {tx_sh[6:0], 1'b0};
        tx_cnt     <= tx_cnt - 3'h1;
      end
    end
  end

  logic next_oe_n;
  assign next_oe_n = ~(selected & ~csn & ~paused & rd_mode & driving
                       & ~(fall & ~rd_mode));
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      serial_out_oe_n <= 1'b1;
    else
      serial_out_oe_n <= next_oe_n;
  end

  //////////////////////////////////////////////////////////////////////
  // apb decode
  logic        acc;
  logic        wr_en;
  logic        hit_st;
  logic        hit_nv;
  logic        hit_rd;
  logic        hit_wi;
  logic        mapped;
  logic [31:0] rd_mux;
  assign acc    = psel & penable;
  assign wr_en  = acc & pready & pwrite;
  assign hit_st = paddr == sef_pkg::OFS_STATUS;
  assign hit_nv = paddr == sef_pkg::OFS_NVBITS;
  assign hit_rd = paddr == sef_pkg::OFS_RDDATA;
  assign hit_wi = paddr == sef_pkg::OFS_WRINFO;
  assign mapped = hit_st | hit_nv | hit_rd | hit_wi;

  logic [31:0] st_word;
  assign st_word = {27'h0, paused, selected, standby, write_enable_latch, busy};
  assign rd_mux = hit_st ? st_word
                : hit_nv ? {24'h0, nvbits}
                : hit_rd ? {24'h0, rd_data}
                : hit_wi ? {8'h00, wi_data, 6'h00, wi_addr}
                : 32'h0000_0000;

  // one wait state, then the answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= acc & ~pready;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= acc & ~pready & ~mapped;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // latch, busy and nonvolatile bits
  logic cyc_end;
  assign cyc_end = busy & (wr_cnt == 32'h0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    // latch and busy cleared, nonvolatile bits reload RST_NVBITS in their own block
    if (!presetn)
    begin
      write_enable_latch     <= 1'b0;
      busy    <= 1'b0;
      wr_kind <= sef_pkg::SEF_IDLE;
      wr_cnt  <= 32'h0;
      nv_pend <= 8'h00;
      wi_addr <= 10'h000;
      wi_data <= 8'h00;
    end
    else
    begin
      if (do_wren)
        write_enable_latch <= 1'b1;
      if (do_wrdi)
        write_enable_latch <= 1'b0;
      // busy high through a write cycle
      if (do_wrsr || do_write)
      begin
        busy    <= 1'b1;
        wr_cnt  <= 32'(WR_CYCLES - 1);
        wr_kind <= do_wrsr ? sef_pkg::SEF_SRWR : sef_pkg::SEF_ARWR;
        nv_pend <= wdata;
        if (do_write)
        begin
          wi_addr <= addr[9:0];
          wi_data <= wdata;
        end
      end
      else if (cyc_end)
      begin
        busy    <= 1'b0;
        write_enable_latch     <= do_wren; // a set in the same cycle wins
        wr_kind <= sef_pkg::SEF_IDLE;
      end
      else if (busy)
        wr_cnt <= wr_cnt - 32'h1;
    end
  end

  // nonvolatile bits: software preload or status write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvbits  <= sef_pkg::RST_NVBITS;
      rd_data <= sef_pkg::RST_RDDATA;
    end
    else
    begin
      if (cyc_end && wr_kind == sef_pkg::SEF_SRWR)
      begin
        nvbits[sef_pkg::NV_LOCK] <= nv_pend[sef_pkg::NV_LOCK];
        nvbits[sef_pkg::NV_GUARD_HI:sef_pkg::NV_GUARD_LO] <=
          nv_pend[sef_pkg::NV_GUARD_HI:sef_pkg::NV_GUARD_LO];
      end
      else if (wr_en && hit_nv)
        nvbits <= pwdata[7:0];
      if (wr_en && hit_rd)
        rd_data <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      standby <= 1'b1;
    else
      standby <= csn & ~busy & ~do_wrsr & ~do_write;
  end

endmodule

/* verilog/sef_pkg.sv */
// constants for the serial eeprom bus front end
package sef_pkg;
  // apb register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_NVBITS = 8'h04;
  localparam logic [7:0] OFS_RDDATA = 8'h08;
  localparam logic [7:0] OFS_WRINFO = 8'h0c;
  // status register field positions
  localparam int ST_BUSY     = 0;
  localparam int ST_WEL      = 1;
  localparam int ST_STANDBY  = 2;
  localparam int ST_SELECTED = 3;
  localparam int ST_PAUSED   = 4;
  // status byte and nvbits register field positions
  localparam int NV_GUARD_LO = 2;
  localparam int NV_GUARD_HI = 3;
  localparam int NV_LOCK     = 7;
  // wrinfo field positions
  localparam int WI_ADDR_HI  = 9;
  localparam int WI_DATA_LO  = 16;
  localparam int WI_DATA_HI  = 23;
  // reset values
  localparam logic [7:0] RST_NVBITS = 8'h00;
  localparam logic [7:0] RST_RDDATA = 8'h00;
  // instruction codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // protected area lower bounds (10-bit array address)
  localparam logic [9:0] GUARD_QUARTER = 10'h300;
  localparam logic [9:0] GUARD_HALF    = 10'h200;
  // byte positions in a transaction
  localparam logic [2:0] BYTE_OP   = 3'h0;
  localparam logic [2:0] BYTE_A1   = 3'h1;
  localparam logic [2:0] BYTE_A2   = 3'h2;
  localparam logic [2:0] BYTE_DATA = 3'h3;
  localparam logic [2:0] BYTE_SAT  = 3'h4;
  // internal write cycle length, in pclk cycles
  localparam int WR_CYCLES_DEF = 200;
  // kind of internal write cycle
  typedef enum logic [1:0] {
    SEF_IDLE = 2'b00,
    SEF_SRWR = 2'b01,
    SEF_ARWR = 2'b10
  } sef_wr_t;
endpackage

/* bench/sef_front_end_asserts.sv */
// port assertions for the serial front end
`timescale 1ns/1ps
module sef_front_end_asserts
(
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // serial pins
  input wire logic        serial_clock_in,
  input wire logic        serial_in,
  input wire logic        select_n,
  input wire logic        pause_n,
  input wire logic        protect_n,
  input wire logic        serial_out,
  input wire logic        serial_out_oe_n,
  // state
  input wire logic        standby
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // access phase still waiting
  wire acc = psel && penable && !pready;
  ////////////////////////////////////////////////////////////////////////
  // apb answer timing and errors
  AST_ONE_WAIT: assert property (acc |=> pready)
    else $error("pready late");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held");
  AST_ERR_MAP: assert property (acc && paddr > 8'h0c |=> pslverr)
    else $error("no slverr");
  AST_ERR_READY: assert property (pslverr |-> pready)
    else $error("stray slverr");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  ////////////////////////////////////////////////////////////////////////
  // serial output and power state
  AST_OFF_DESEL: assert property (
    select_n [*5] |-> serial_out_oe_n) else $error("drives deselected");
  AST_OFF_PAUSE: assert property (
    !pause_n [*8] |-> serial_out_oe_n) else $error("drives paused");
  AST_OUT_ON_FALL: assert property (
    !serial_out_oe_n && $past(!serial_out_oe_n) && $changed(serial_out)
    |-> !$past(serial_clock_in, 2)) else $error("out moved clock high");
  AST_SEL_ACTIVE: assert property (
    $fell(select_n) ##1 !select_n [*5] |-> !standby)
    else $error("standby while selected");
  // main scenarios
  cover property (pslverr);
  cover property ($fell(serial_out_oe_n));
  cover property ((!pause_n && !select_n) [*8]);
endmodule

/* bench/sef_spi_master.sv */
// mode 0 serial master model for the eeprom pins
`timescale 1ns/1ps
module sef_spi_master
(
  // timing
  input  wire logic pclk,
  // pins
  output logic      sck,
  output logic      mosi,
  output logic      sel_n,
  output logic      hold_n,
  input  wire logic miso
);
  initial
  begin
    sck = 1'b0;
    mosi = 1'b1;
    sel_n = 1'b1;
    hold_n = 1'b1;
  end
  // wait clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic start();
    sel_n <= 1'b0;
    tick(4);
  endtask
  task automatic stop();
    tick(4);
    sel_n <= 1'b1;
    mosi <= ~mosi;
    tick(4);
  endtask
  task automatic pause(input logic p);
    tick(2);
    hold_n <= ~p;
    tick(4);
  endtask
  // set on fall, sample on rise
  task automatic bit_io(input logic d, output logic o);
    mosi <= d;
    tick(4);
    sck <= 1'b1;
    tick(2);
    o = miso;
    tick(2);
    sck <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
  endtask
endmodule

/* bench/serial_eeprom_bus_front_end_test.sv */
// self-checking bench for the serial front end
`timescale 1ns/1ps
module serial_eeprom_bus_front_end_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        sck, mosi, sel_n, hold_n, miso, so, so_oe_n, standby;
  logic        wp_n;
  logic [7:0]  q;
  logic        b;
  int          bad_count;
  int          check_count;
  // released output shows inverse of last bit
  assign miso = so_oe_n ? ~so : so;
  sef_front_end #(.WR_CYCLES(40)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_in(sck), .serial_in(mosi), .select_n(sel_n),
    .pause_n(hold_n), .protect_n(wp_n), .serial_out(so),
    .serial_out_oe_n(so_oe_n), .standby(standby));
  sef_spi_master m (.pclk(pclk), .sck(sck), .mosi(mosi), .sel_n(sel_n),
    .hold_n(hold_n), .miso(miso));
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer, entered just after an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    b = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  // whole frame of n bytes, last byte read back in q
  task automatic sendf(input logic [31:0] w, input int n);
    m.start();
    for (int i = n - 1; i >= 0; i--)
      m.xfer(w[8*i +: 8], q);
    m.stop();
  endtask
  task automatic t_reset();
    chk({standby, so_oe_n}, 2'b11);
    rd(sef_pkg::OFS_STATUS, 32'h4);
    rd(sef_pkg::OFS_NVBITS, 32'h0);
    rd(8'h10, 32'h0);
    chk(b, 1'b1);
  endtask
  task automatic t_por();
    // select held low through the power cycle, so the following wren is ignored
    presetn <= 1'b0;
    m.start();
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    m.xfer(sef_pkg::OP_WREN, q);
    m.stop();
    rd(sef_pkg::OFS_STATUS, 32'h4);
  endtask
  task automatic t_frames();
    sendf(32'h06, 1);
    rd(sef_pkg::OFS_STATUS, 32'h6);
    sendf(32'h04, 1);
    rd(sef_pkg::OFS_STATUS, 32'h4);
    m.start();
    m.xfer(sef_pkg::OP_WREN, q);
    m.bit_io(1'b0, b);
    m.stop();
    rd(sef_pkg::OFS_STATUS, 32'h4);
    sendf(32'hff06, 2);
    rd(sef_pkg::OFS_STATUS, 32'h4);
    m.start();
    repeat (3) m.bit_io(1'b0, b);
    m.stop();
    sendf(32'h06, 1);
    rd(sef_pkg::OFS_STATUS, 32'h6);
  endtask
  task automatic t_reads();
    wr(sef_pkg::OFS_NVBITS, 32'h8c);
    rd(sef_pkg::OFS_NVBITS, 32'h8c);
    sendf(32'h0500, 2);
    chk(q, 8'h8e);
    wr(sef_pkg::OFS_NVBITS, 32'h0);
    wr(sef_pkg::OFS_RDDATA, 32'ha5);
    sendf(32'h03001000, 4);
    chk(q, 8'ha5);
  endtask
  task automatic t_write();
    sendf(32'h0201235a, 4);
    rd(sef_pkg::OFS_STATUS, 32'h3);
    rd(sef_pkg::OFS_WRINFO, 32'h005a0123);
    repeat (60) @(posedge pclk);
    rd(sef_pkg::OFS_STATUS, 32'h4);
  endtask
  task automatic t_pause(input logic [7:0] op, input logic brk);
    m.start();
    for (int i = 7; i >= 0; i--)
    begin
      m.bit_io(op[i], b);
      if (i == 4)
      begin
        m.pause(1'b1);
        rd(sef_pkg::OFS_STATUS, {27'h0, 2'b11, 1'b0, brk, 1'b0});
        repeat (3) m.bit_io(1'b1, b);
        if (brk)
          break;
        m.pause(1'b0);
      end
    end
    m.stop();
    m.pause(1'b0);
    rd(sef_pkg::OFS_STATUS, 32'h6);
  endtask
  task automatic t_protect();
    wr(sef_pkg::OFS_NVBITS, 32'h80);
    // protect held low across the write
    wp_n <= 1'b0;
    sendf(32'h06, 1);
    sendf(32'h010c, 2);
    rd(sef_pkg::OFS_STATUS, 32'h6);
    rd(sef_pkg::OFS_NVBITS, 32'h80);
    // protect held high across the write
    wp_n <= 1'b1;
    sendf(32'h010c, 2);
    rd(sef_pkg::OFS_STATUS, 32'h3);
    repeat (60) @(posedge pclk);
    rd(sef_pkg::OFS_NVBITS, 32'h0c);
    rd(sef_pkg::OFS_STATUS, 32'h4);
    sendf(32'h06, 1);
    sendf(32'h02012377, 4);
    rd(sef_pkg::OFS_STATUS, 32'h6);
    rd(sef_pkg::OFS_WRINFO, 32'h005a0123);
    wr(sef_pkg::OFS_NVBITS, 32'h0);
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
  // main sequence
  initial
  begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    wp_n = 1'b1;
    bad_count = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_por();
    t_frames();
    t_reads();
    t_write();
    t_pause(sef_pkg::OP_WREN, 1'b0);
    t_pause(sef_pkg::OP_WRDI, 1'b1);
    t_protect();
    print_verdict();
  end
endmodule
// checker on the design ports
bind sef_front_end sef_front_end_asserts u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .serial_clock_in(serial_clock_in),
  .serial_in(serial_in), .select_n(select_n), .pause_n(pause_n),
  .protect_n(protect_n), .serial_out(serial_out),
  .serial_out_oe_n(serial_out_oe_n), .standby(standby));
